/* File: hw/wesl_pkg.sv */
package wesl_pkg;

	// ------------------------------------------------------------
	// register map, byte offsets from the runtime base
	// ------------------------------------------------------------
	localparam logic [2:0] OFF_SUMMARY = 3'h0;
	localparam logic [2:0] OFF_RSVD_ONE = 3'h1;
	localparam logic [2:0] OFF_GLOBAL_EN = 3'h2;
	localparam logic [2:0] OFF_RSVD_THREE = 3'h3;
	localparam logic [2:0] OFF_SRC_PERIPH = 3'h4;
	localparam logic [2:0] OFF_SRC_PINS_A = 3'h5;
	localparam logic [2:0] OFF_SRC_PINS_B = 3'h6;
	localparam int NUM_SRC_REGS = 3;
	localparam int WINDOW_BITS = 3;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int SUMMARY_FLAG_POS = 0;
	localparam int GLOBAL_EN_POS = 0;
	localparam int GROUPED_IRQ_POS = 3;
	localparam logic RST_SUMMARY_FLAG = 1'b0;
	localparam logic RST_GLOBAL_EN = 1'b0;
	localparam logic RST_WAKE_REQ_N = 1'b1;
	localparam logic [7:0] RST_SRC_STATUS = 8'h00;
	localparam logic [7:0] RST_READ_DATA = 8'h00;
	// bit 0 of the peripheral status register has no source
	localparam logic [23:0] SRC_IMPL_MASK = 24'hfffffe;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] data;
	} wesl_io_req_t;

	// bit order per register: [7:0] peripherals, [15:8] pins a, [23:16] pins b
	typedef struct packed {
		logic [7:0] pinsB;
		logic [7:0] pinsA;
		logic [7:0] periph;
	} wesl_src_vec_t;

endpackage

/* File: hw/wesl_status_bank.sv */
`timescale 1ns/1ps
module wesl_status_bank (
	// clock and standby reset
	input wire logic clock,
	input wire logic rst,
	// event and write-one-to-clear
	input wire logic [7:0] setVec,
	input wire logic [7:0] clrVec,
	// state
	output logic [7:0] statusQ
);
	import wesl_pkg::*;

	// ------------------------------------------------------------
	// sticky bits, set wins over a same-cycle clear
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			statusQ <= RST_SRC_STATUS;
		end else begin
			statusQ <= (statusQ & ~clrVec) | setVec;
		end
	end

	a_set_always: assert property (@(posedge clock) disable iff (rst)
		setVec != 8'h00 |=> (statusQ & $past(setVec)) == $past(setVec))
		else $error("event did not set its status bit");

	a_clear_one: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> (statusQ & ~$past(setVec) & $past(clrVec)) == 8'h00 &&
			(statusQ & ~$past(clrVec)) == (($past(statusQ) | $past(setVec)) & ~$past(clrVec)))
		else $error("write-one-to-clear misbehaved");

endmodule

/* File: hw/wesl_wake_logic.sv */
`timescale 1ns/1ps
// Operation
// - summary flag sets whenever a wake request would be driven, ignoring global enable; here it sets only when an enabled source newly becomes pending
// - summary flag survives all resets except standby power-on reset
// - writing one clears summary flag and stops the request; zero does nothing
// - bits 7..1 of summary and enable, offsets 01 and 03 read zero
// - global enable bit gates the wake request; zero by default blocks it
// - global enable survives all resets except standby power-on reset
// - source status bit sets on its event regardless of any enable
// - peripheral status: bit0 reserved, ring2, ring1, keyboard, mouse, key, fan1, fan2
// - pins-a status holds gpio 10 to 17 in bits 0 to 7
// - pins-b status: gpio 20-22, grouped irq at bit 3, gpio 24-27
// - source status survives all resets except standby power-on reset
// - writing one clears a source status bit, zero leaves it
// - a source requests wake only with its enable, status and global enable set
// - registers decode at byte offsets from the programmed runtime base
module wesl_wake_logic (
	// clock and standby power-on reset
	input wire logic clock,
	input wire logic rst,
	// host i/o access
	input wire logic [15:0] runtimeBase,
	input wesl_pkg::wesl_io_req_t ioReq,
	output logic [7:0] ioRdData,
	// wake sources, level high while an event is raised
	input wire logic ringIndicatorSecond,
	input wire logic ringIndicatorFirst,
	input wire logic keyboardWake,
	input wire logic mouseWake,
	input wire logic specificKeyWake,
	input wire logic fanSpeedInputFirst,
	input wire logic fanSpeedInputSecond,
	input wire logic [7:0] gpioPinsLow,
	input wire logic [2:0] gpioPins2022,
	input wire logic groupedDeviceIrqStatus,
	input wire logic [3:0] gpioPins2427,
	// per-source enables held elsewhere
	input wesl_pkg::wesl_src_vec_t srcEnable,
	// wake request to the chipset
	output logic wakeRequestN
);
	import wesl_pkg::*;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic [15:0] offset;
	logic inWindow;
	logic [2:0] regSel;
	logic wrHit;
	logic rdHit;

	always_comb begin
		offset = ioReq.addr - runtimeBase;
		inWindow = (offset[15:WINDOW_BITS] == 13'h0000);
		regSel = offset[WINDOW_BITS-1:0];
		wrHit = ioReq.wr && inWindow;
		rdHit = ioReq.rd && inWindow;
	end

	// ------------------------------------------------------------
	// source status registers
	// ------------------------------------------------------------
	wesl_src_vec_t eventVec;
	logic [23:0] statusAll;
	logic [23:0] pendingPrev_q;
	logic [23:0] pendingVec;

	always_comb begin
		eventVec.periph = {fanSpeedInputSecond, fanSpeedInputFirst, specificKeyWake, mouseWake,
			keyboardWake, ringIndicatorFirst, ringIndicatorSecond, 1'b0};
		eventVec.pinsA = gpioPinsLow;
		eventVec.pinsB = {gpioPins2427, groupedDeviceIrqStatus, gpioPins2022};
	end

	generate
		for (genvar g = 0; g < NUM_SRC_REGS; g++) begin : gSrc
			logic [7:0] clrVec;
			always_comb begin
				clrVec = (wrHit && regSel == OFF_SRC_PERIPH + 3'(g)) ? ioReq.data : 8'h00;
			end
			wesl_status_bank uBank (
				.clock(clock),
				.rst(rst),
				.setVec(eventVec[g*8 +: 8] & SRC_IMPL_MASK[g*8 +: 8]),
				.clrVec(clrVec),
				.statusQ(statusAll[g*8 +: 8])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// summary flag and global enable
	// ------------------------------------------------------------
	logic summaryFlag_q;
	logic globalEnable_q;
	logic newPending;

	// flag fires on a fresh pending source, so a cleared flag stays quiet
	// until another event, even while older statuses remain set
	always_comb begin
		pendingVec = statusAll & srcEnable;
		newPending = |(pendingVec & ~pendingPrev_q);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pendingPrev_q <= 24'h000000;
		end else begin
			pendingPrev_q <= pendingVec;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			summaryFlag_q <= RST_SUMMARY_FLAG;
		end else if (newPending) begin
			summaryFlag_q <= 1'b1;
		end else if (wrHit && regSel == OFF_SUMMARY && ioReq.data[SUMMARY_FLAG_POS]) begin
			summaryFlag_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			globalEnable_q <= RST_GLOBAL_EN;
		end else if (wrHit && regSel == OFF_GLOBAL_EN) begin
			globalEnable_q <= ioReq.data[GLOBAL_EN_POS];
		end
	end

	// ------------------------------------------------------------
	// wake request output
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wakeRequestN <= RST_WAKE_REQ_N;
		end else begin
			wakeRequestN <= ~(globalEnable_q && summaryFlag_q && |pendingVec);
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [7:0] rdValue;

	always_comb begin
		case (regSel)
			OFF_SUMMARY: rdValue = {7'h00, summaryFlag_q};
			OFF_GLOBAL_EN: rdValue = {7'h00, globalEnable_q};
			OFF_SRC_PERIPH: rdValue = statusAll[7:0];
			OFF_SRC_PINS_A: rdValue = statusAll[15:8];
			OFF_SRC_PINS_B: rdValue = statusAll[23:16];
			default: rdValue = 8'h00;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ioRdData <= RST_READ_DATA;
		end else if (rdHit) begin
			ioRdData <= rdValue;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_flag_on_pending: assert property (@(posedge clock) disable iff (rst)
		newPending |=> summaryFlag_q)
		else $error("summary flag missed a new pending source");

	a_flag_w1c: assert property (@(posedge clock) disable iff (rst)
		(wrHit && regSel == OFF_SUMMARY && ioReq.data[0] && !newPending) |=> !summaryFlag_q ##1 wakeRequestN)
		else $error("summary clear did not drop the request");

	a_flag_hold: assert property (@(posedge clock) disable iff (rst)
		(summaryFlag_q && !(wrHit && regSel == OFF_SUMMARY && ioReq.data[0])) |=> summaryFlag_q)
		else $error("summary flag lost without a clear");

	a_enable_gate: assert property (@(posedge clock) disable iff (rst)
		!globalEnable_q |=> wakeRequestN)
		else $error("request driven with global enable low");

	a_request_drive: assert property (@(posedge clock) disable iff (rst)
		(globalEnable_q && summaryFlag_q && pendingVec != 24'h000000) |=> !wakeRequestN)
		else $error("request not driven while pending");

	a_enable_write: assert property (@(posedge clock) disable iff (rst)
		(wrHit && regSel == OFF_GLOBAL_EN) |=> globalEnable_q == $past(ioReq.data[0]))
		else $error("global enable write lost");

	a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
		(rdHit && (regSel == OFF_RSVD_ONE || regSel == OFF_RSVD_THREE)) |=> ioRdData == 8'h00)
		else $error("reserved offset read nonzero");

	a_summary_read: assert property (@(posedge clock) disable iff (rst)
		(rdHit && regSel == OFF_SUMMARY) |=> ioRdData == {7'h00, $past(summaryFlag_q)})
		else $error("summary read wrong");

	a_no_outside: assert property (@(posedge clock) disable iff (rst)
		(ioReq.wr && !inWindow) |=> $stable(globalEnable_q))
		else $error("write outside window changed state");

	a_idle_request: assert property (@(posedge clock) disable iff (rst)
		(pendingVec == 24'h000000) |=> wakeRequestN)
		else $error("request driven with nothing pending");

	a_enable_read: assert property (@(posedge clock) disable iff (rst)
		(rdHit && regSel == OFF_GLOBAL_EN) |=> ioRdData == {7'h00, $past(globalEnable_q)})
		else $error("global enable read wrong");

	a_source_read: assert property (@(posedge clock) disable iff (rst)
		(rdHit && regSel == OFF_SRC_PERIPH) |=> {16'h0000, ioRdData} == ($past(statusAll) & 24'h0000ff))
		else $error("peripheral status read wrong");

	a_read_hold: assert property (@(posedge clock) disable iff (rst)
		!rdHit |=> $stable(ioRdData))
		else $error("read data changed without a read hit");

	a_enable_hold: assert property (@(posedge clock) disable iff (rst)
		!(wrHit && regSel == OFF_GLOBAL_EN) |=> $stable(globalEnable_q))
		else $error("global enable changed without a write");

endmodule

/* File: bench/wesl_host_model.sv */
`timescale 1ns/1ps
module wesl_host_model (
	// clock and standby reset
	input wire logic clock,
	input wire logic rst,
	// wake request from the device
	input wire logic wakeRequestN,
	output logic [7:0] wakeCount_q
);
	logic lastN_q;
	// counts falling edges only: a held request is one wake
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lastN_q <= 1'b1;
			wakeCount_q <= 8'h00;
		end else begin
			lastN_q <= wakeRequestN;
			if (lastN_q && !wakeRequestN) begin
				wakeCount_q <= wakeCount_q + 8'h01;
			end
		end
	end
endmodule

/* File: bench/wesl_wake_logic_tb.sv */
`timescale 1ns/1ps
module wesl_wake_logic_tb;
	import wesl_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [15:0] base = 16'h3a40;
	wesl_io_req_t req = '0;
	logic [7:0] rdData;
	logic [23:0] ev = 24'h0;
	wesl_src_vec_t en = '0;
	logic wakeN;
	logic [7:0] wakeCount;
	logic [31:0] seed = 32'hde24;
	logic [7:0] d;
	logic [23:0] pat;
	int mismatches = 0;
	int total_checks = 0;
	always #12.5 clock = ~clock;
	wesl_wake_logic uut (.clock(clock), .rst(rst), .runtimeBase(base), .ioReq(req), .ioRdData(rdData),
		.ringIndicatorSecond(ev[1]), .ringIndicatorFirst(ev[2]), .keyboardWake(ev[3]), .mouseWake(ev[4]),
		.specificKeyWake(ev[5]), .fanSpeedInputFirst(ev[6]), .fanSpeedInputSecond(ev[7]),
		.gpioPinsLow(ev[15:8]), .gpioPins2022(ev[18:16]), .groupedDeviceIrqStatus(ev[19]),
		.gpioPins2427(ev[23:20]), .srcEnable(en), .wakeRequestN(wakeN));
	wesl_host_model host (.clock(clock), .rst(rst), .wakeRequestN(wakeN), .wakeCount_q(wakeCount));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] off, input logic [7:0] v);
		@(posedge clock) req <= {base + 16'(off), 1'b1, 1'b0, v};
		@(posedge clock) req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] off, output logic [7:0] v);
		@(posedge clock) req <= {base + 16'(off), 1'b0, 1'b1, 8'h00};
		@(posedge clock) req.rd <= 1'b0;
		#1 v = rdData;
	endtask
	task automatic pulse(input logic [23:0] p);
		@(posedge clock) ev <= p;
		@(posedge clock) ev <= 24'h0;
	endtask
	task automatic chkSrc(input logic [23:0] e);
		logic [7:0] v;
		for (int i = 0; i < 3; i++) begin
			rd(4'(4 + i), v);
			chk("source status", v, e[8 * i +: 8]);
		end
	endtask
	task automatic chkWake(input logic e);
		#1 chk("wake request", {7'h0, wakeN}, {7'h0, e});
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd(4'(i), d);
			chk("reset value", d, 8'h00);
		end
		wr(1, 8'hff);
		wr(3, 8'hff);
		wr(2, 8'hff);
		wr(0, 8'hff);
		rd(1, d);
		chk("gap one", d, 8'h00);
		rd(3, d);
		chk("gap three", d, 8'h00);
		rd(2, d);
		chk("global enable", d, 8'h01);
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			pat = (k == 0) ? 24'hffffff : (k == 1) ? 24'h000001 : seed[23:0];
			pulse(pat);
			chkSrc(pat & SRC_IMPL_MASK);
			chkWake(1'b1);
			seed = lfsr(seed);
			for (int i = 0; i < 3; i++) wr(4'(4 + i), seed[8 * i +: 8]);
			chkSrc(pat & SRC_IMPL_MASK & ~seed[23:0]);
			for (int i = 0; i < 3; i++) wr(4'(4 + i), 8'hff);
		end
		// keyboard source enabled, global enable still set
		@(posedge clock) en <= 24'h000008;
		pulse(24'h000008);
		repeat (2) @(posedge clock);
		chkWake(1'b0);
		rd(0, d);
		chk("summary flag", d, 8'h01);
		chk("wakes seen", wakeCount, 8'h01);
		wr(0, 8'h00);
		rd(0, d);
		chk("summary flag", d, 8'h01);
		wr(0, 8'h01);
		repeat (2) @(posedge clock);
		chkWake(1'b1);
		rd(0, d);
		chk("summary flag", d, 8'h00);
		// global enable off: flag still sets, request blocked
		wr(4, 8'hff);
		wr(2, 8'h00);
		pulse(24'h000008);
		repeat (3) @(posedge clock);
		chkWake(1'b1);
		rd(0, d);
		chk("summary flag", d, 8'h01);
		wr(10, 8'h01);
		rd(2, d);
		chk("outside window", d, 8'h00);
		@(posedge clock) base <= base + 16'h0100;
		wr(2, 8'h01);
		rd(2, d);
		chk("moved base", d, 8'h01);
		// event and clear in one cycle: the event wins
		@(posedge clock) begin
			ev <= 24'h000010;
			req <= {base + 16'h0004, 1'b1, 1'b0, 8'h10};
		end
		@(posedge clock) begin
			ev <= 24'h0;
			req.wr <= 1'b0;
		end
		chkSrc(24'h000018);
		@(posedge clock) rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(0, d);
		chk("standby reset", d, 8'h00);
		rd(2, d);
		chk("standby reset", d, 8'h00);
		chkSrc(24'h000000);
		chkWake(1'b1);
		end_of_test;
	end
	initial begin
		#200000;
		mismatches++;
		end_of_test;
	end
endmodule
